// file: design/dpi_top.sv
// DMA program port: channel registers, masks, modes and bus timing config
`timescale 1ns/100ps
`include "dpi_params.svh"

// ====================================================================
// Notes on behaviour
// - Address write loads base and current byte
// - Count write loads base and current byte
// - Single mask port sets or clears one mask
// - Mode bits 7:6 choose operating style
// - Bit 5 decrements address; bit 4 auto-reloads
// - Transfer type field; code 11 illegal
// - Mode bits 1:0 choose target channel
// - Pointer port read sets the byte toggle
// - Pointer port write clears the byte toggle
// - Temporary register keeps first memory-copy byte
// - Master clear resets byte toggle, mode readback, masks and temp register
// - Mode readback restarts, then channels 0..3
// - Clear-mask write enables all four channels
// - All-mask register, bit 3 is channel 0
// - Config bits 7:6 set I/O wait states
// - Config bits 5:4 set 16-bit DMA waits
// - Config bits 3:2 set 8-bit DMA waits
// - Config bit 1 aligns memory read strobe
// - DMA always clocked from the bus clock
module dpi_top
#(
   parameter int NUM_CH = 4                       // Channels in this unit
)
(
   input  wire logic                    clk_in,
   input  wire logic                    nrst_in,
   input  wire logic [9:0]              io_addr_in,
   input  wire logic                    io_read_strobe_n_in,
   input  wire logic                    io_write_strobe_n_in,
   input  wire logic [7:0]              buffered_data_lines_in,
   output logic      [7:0]              buffered_data_lines_out,
   output logic                         buffered_data_lines_oe_n_out,
   input  wire logic                    mem_copy_first_in,
   input  wire logic                    transfer_done_in,
   input  wire logic                    dma_io_write_start_in,
   input  wire logic                    dma_cycle_end_in,
   output logic                         io_write_strobe_n_out,
   output logic                         memory_read_strobe_n_out,
   output logic                         terminal_count_out,
   output logic      [NUM_CH-1:0]       channel_mask_out,
   output dpi_pkg::dpi_mode_t [NUM_CH-1:0] channel_mode_out,
   output logic                         illegal_mode_out,
   output logic      [15:0]             current_address_out,
   output logic      [15:0]             current_count_out,
   output logic      [2:0]              io_wait_states_out,
   output logic      [2:0]              dma16_wait_states_out,
   output logic      [2:0]              dma8_wait_states_out
);
   import dpi_pkg::*;

   // =================================================================
   // Helpers

   // Two-bit wait field to a count of one to four wait states
   function automatic logic [2:0] wait_count(input logic [1:0] field);
      wait_count = {1'b0, field} + 3'h1;
   endfunction

   // One-hot strobe sequencer states
   typedef enum logic [2:0] {
      DPI_SEQ_IDLE   = 3'b001,
      DPI_SEQ_DELAY  = 3'b010,
      DPI_SEQ_ACTIVE = 3'b100
   } dpi_seq_t;

   // =================================================================
   // Storage
   logic              rd_prev_n;        // Read strobe one cycle ago
   logic              wr_prev_n;        // Write strobe one cycle ago
   logic              byte_pointer_toggle; // Low byte when 0
   logic [1:0]        readback_index;   // Next mode to read back
   logic [NUM_CH-1:0] mask;             // One is channel disabled
   dpi_mode_t [NUM_CH-1:0] mode;        // Stored channel modes
   logic [15:0]       base_address;     // Reload value of address
   logic [15:0]       current_address;  // Live address
   logic [15:0]       base_count;       // Reload value of count
   logic [15:0]       current_count;    // Live count
   logic [7:0]        temporary_data;   // Memory-copy holding byte
   logic [7:0]        cfg_index;        // Selected config index
   dpi_cfg_t          bus_timing_config; // Wait and strobe timing
   logic [7:0]        read_data;        // Registered read answer
   logic              drive;            // Read answer is on the lines
   dpi_seq_t          seq;              // Strobe sequencer state
   dpi_seq_t          next_seq;         // Next sequencer state
   logic              tc;               // Registered terminal count

   // =================================================================
   // Access decode; strobes are level, act once on their leading edge
   logic rd_start;
   logic wr_start;
   logic master_clear;
   logic word_access;
   logic [7:0] wdata;
   assign rd_start = ~io_read_strobe_n_in & rd_prev_n;
   assign wr_start = ~io_write_strobe_n_in & wr_prev_n;
   assign wdata    = buffered_data_lines_in;
   assign master_clear = wr_start & (io_addr_in == `DPI_PORT_TEMPCLEAR);
   assign word_access  = (rd_start | wr_start) &
                         ((io_addr_in == `DPI_PORT_ADDRESS0) |
                          (io_addr_in == `DPI_PORT_COUNT0));

   // Strobe history for the leading-edge detectors
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rd_prev_n <= 1'b1;
         wr_prev_n <= 1'b1;
      end
      else
      begin
         rd_prev_n <= io_read_strobe_n_in;
         wr_prev_n <= io_write_strobe_n_in;
      end
   end

   // =================================================================
   // Byte pointer toggle
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         byte_pointer_toggle <= 1'b0;
      else if (master_clear)
         byte_pointer_toggle <= 1'b0;
      else if (rd_start && io_addr_in == `DPI_PORT_POINTER)
         byte_pointer_toggle <= 1'b1;
      else if (wr_start && io_addr_in == `DPI_PORT_POINTER)
         byte_pointer_toggle <= 1'b0;
      else if (word_access)
         byte_pointer_toggle <= ~byte_pointer_toggle;
   end

   // =================================================================
   // Mode readback counter; restarts so channel 0 comes first
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         readback_index <= 2'h0;
      else if (master_clear)
         readback_index <= 2'h0;
      else if (rd_start && io_addr_in == `DPI_PORT_MODECLEAR)
         readback_index <= 2'h0;
      else if (rd_start && io_addr_in == `DPI_PORT_MODE)
         readback_index <= readback_index + 2'h1;
   end

   // =================================================================
   // Channel masks; each command has its own port, so none collide
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         mask <= `DPI_RST_MASK;
      else if (master_clear)
         mask <= `DPI_RST_MASK;
      else if (wr_start && io_addr_in == `DPI_PORT_MODECLEAR)
         mask <= '0;
      else if (wr_start && io_addr_in == `DPI_PORT_SINGLEMASK)
         mask[wdata[1:0]] <= wdata[`DPI_SMASK_SET_BIT];
      else if (wr_start && io_addr_in == `DPI_PORT_ALLMASK)
         mask <= {wdata[0], wdata[1], wdata[2], wdata[3]};
   end

   // =================================================================
   // Mode registers; the write's own low bits pick the channel
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_mode
         always_ff @(posedge clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
               mode[ch] <= `DPI_RST_MODE;
            else if (wr_start && io_addr_in == `DPI_PORT_MODE &&
                     wdata[1:0] == 2'(ch))
            begin
               mode[ch].style     <= dpi_style_t'(
                  wdata[`DPI_MODE_STYLE_HI:`DPI_MODE_STYLE_LO]);
               mode[ch].decrement <= wdata[`DPI_MODE_DEC_BIT];
               mode[ch].auto_init <= wdata[`DPI_MODE_AUTO_BIT];
               mode[ch].xfer      <= dpi_xfer_t'(
                  wdata[`DPI_MODE_TYPE_HI:`DPI_MODE_TYPE_LO]);
            end
         end
      end
   endgenerate

   // =================================================================
   // Channel 0 address and count; a host load wins over a transfer
   // step in the same cycle, so software always sees its own value
   logic tc_now;
   assign tc_now = transfer_done_in && current_count == 16'h0000;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         base_address    <= `DPI_RST_WORD;
         current_address <= `DPI_RST_WORD;
         base_count      <= `DPI_RST_WORD;
         current_count   <= `DPI_RST_WORD;
      end
      else if (wr_start && io_addr_in == `DPI_PORT_ADDRESS0)
      begin
         if (byte_pointer_toggle)
         begin
            base_address[15:8]    <= wdata;
            current_address[15:8] <= wdata;
         end
         else
         begin
            base_address[7:0]    <= wdata;
            current_address[7:0] <= wdata;
         end
      end
      else if (wr_start && io_addr_in == `DPI_PORT_COUNT0)
      begin
         if (byte_pointer_toggle)
         begin
            base_count[15:8]    <= wdata;
            current_count[15:8] <= wdata;
         end
         else
         begin
            base_count[7:0]    <= wdata;
            current_count[7:0] <= wdata;
         end
      end
      else if (tc_now && mode[0].auto_init)
      begin
         current_address <= base_address;
         current_count   <= base_count;
      end
      else if (transfer_done_in)
      begin
         current_address <= mode[0].decrement ?
                            current_address - 16'h0001 :
                            current_address + 16'h0001;
         current_count   <= current_count - 16'h0001;
      end
   end

   // Terminal count flag, one cycle per rollover
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         tc <= 1'b0;
      else
         tc <= tc_now;
   end

   // =================================================================
   // Temporary register, only a memory copy or a clear touches it
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         temporary_data <= `DPI_RST_TEMP;
      else if (master_clear)
         temporary_data <= `DPI_RST_TEMP;
      else if (mem_copy_first_in)
         temporary_data <= buffered_data_lines_in;
   end

   // =================================================================
   // Configuration index and data pair
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         cfg_index         <= `DPI_RST_INDEX;
         bus_timing_config <= `DPI_RST_CFG;
      end
      else if (wr_start && io_addr_in == `DPI_PORT_CFG_INDEX)
         cfg_index <= wdata;
      else if (wr_start && io_addr_in == `DPI_PORT_CFG_DATA &&
               cfg_index == `DPI_IDX_BUS_TIMING)
         bus_timing_config <= wdata;
   end

   // =================================================================
   // Read answer, captured on the read strobe edge and held while
   // the strobe stays low; unknown ports leave the lines undriven
   logic [7:0] read_mux;
   logic       read_hit;
   always_comb
   begin
      read_mux = 8'h00;
      read_hit = 1'b1;
      case (io_addr_in)
         `DPI_PORT_ADDRESS0:
            read_mux = byte_pointer_toggle ? current_address[15:8] :
                       current_address[7:0];
         `DPI_PORT_COUNT0:
            read_mux = byte_pointer_toggle ? current_count[15:8] :
                       current_count[7:0];
         `DPI_PORT_MODE:
            read_mux = {mode[readback_index], readback_index};
         `DPI_PORT_POINTER, `DPI_PORT_MODECLEAR:
            read_mux = 8'h00;
         `DPI_PORT_TEMPCLEAR:
            read_mux = temporary_data;
         `DPI_PORT_ALLMASK:
            read_mux = {4'h0, mask[0], mask[1], mask[2], mask[3]};
         `DPI_PORT_CFG_INDEX:
            read_mux = cfg_index;
         `DPI_PORT_CFG_DATA:
            read_mux = (cfg_index == `DPI_IDX_BUS_TIMING) ?
                       bus_timing_config : 8'h00;
         default:
            read_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         read_data <= 8'h00;
         drive     <= 1'b0;
      end
      else if (rd_start)
      begin
         read_data <= read_mux;
         drive     <= read_hit;
      end
      else if (io_read_strobe_n_in)
         drive <= 1'b0;
   end

   // =================================================================
   // DMA strobe sequencer; the memory read strobe either joins the
   // I/O write strobe or trails it by one clock
   always_comb
   begin
      next_seq = seq;
      case (seq)
         DPI_SEQ_IDLE:
            if (dma_io_write_start_in)
               next_seq = bus_timing_config.early_read ?
                          DPI_SEQ_ACTIVE : DPI_SEQ_DELAY;
         DPI_SEQ_DELAY:
            next_seq = dma_cycle_end_in ? DPI_SEQ_IDLE : DPI_SEQ_ACTIVE;
         DPI_SEQ_ACTIVE:
            if (dma_cycle_end_in)
               next_seq = DPI_SEQ_IDLE;
         default:
            next_seq = DPI_SEQ_IDLE;
      endcase
   end

   // Sequencer runs on the single bus clock whatever the source bit
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         seq <= DPI_SEQ_IDLE;
      else
         seq <= next_seq;
   end

   // =================================================================
   // Outputs
   assign buffered_data_lines_out      = read_data;
   assign buffered_data_lines_oe_n_out = ~drive;
   assign io_write_strobe_n_out        = (seq == DPI_SEQ_IDLE);
   assign memory_read_strobe_n_out     = (seq != DPI_SEQ_ACTIVE);
   assign terminal_count_out           = tc;
   assign channel_mask_out             = mask;
   assign channel_mode_out             = mode;
   assign current_address_out          = current_address;
   assign current_count_out            = current_count;
   assign io_wait_states_out = wait_count(bus_timing_config.io_ws);
   assign dma16_wait_states_out =
      wait_count(bus_timing_config.dma16_ws);
   assign dma8_wait_states_out =
      wait_count(bus_timing_config.dma8_ws);

   // Flags any channel holding the forbidden transfer code
   always_comb
   begin
      illegal_mode_out = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
         if (mode[i].xfer == DPI_XFER_ILLEGAL)
            illegal_mode_out = 1'b1;
   end

endmodule

// file: design/dpi_params.svh
// Offsets, fields, resets and timing counts of the DMA program port
`ifndef DPI_PARAMS_SVH
`define DPI_PARAMS_SVH

// ====================================================================
// I/O port offsets
`define DPI_PORT_ADDRESS0   10'h000
`define DPI_PORT_COUNT0     10'h001
`define DPI_PORT_SINGLEMASK 10'h00a
`define DPI_PORT_MODE       10'h00b
`define DPI_PORT_POINTER    10'h00c
`define DPI_PORT_TEMPCLEAR  10'h00d
`define DPI_PORT_MODECLEAR  10'h00e
`define DPI_PORT_ALLMASK    10'h00f
`define DPI_PORT_CFG_INDEX  10'h022
`define DPI_PORT_CFG_DATA   10'h023

// ====================================================================
// Configuration index of the bus timing register
`define DPI_IDX_BUS_TIMING  8'h01

// ====================================================================
// Field positions
`define DPI_SMASK_SET_BIT   2
`define DPI_MODE_STYLE_HI   7
`define DPI_MODE_STYLE_LO   6
`define DPI_MODE_DEC_BIT    5
`define DPI_MODE_AUTO_BIT   4
`define DPI_MODE_TYPE_HI    3
`define DPI_MODE_TYPE_LO    2
`define DPI_CFG_IOWS_HI     7
`define DPI_CFG_IOWS_LO     6
`define DPI_CFG_DMA16_HI    5
`define DPI_CFG_DMA16_LO    4
`define DPI_CFG_DMA8_HI     3
`define DPI_CFG_DMA8_LO     2
`define DPI_CFG_EARLY_BIT   1
`define DPI_CFG_CLKSRC_BIT  0

// ====================================================================
// Reset values
`define DPI_RST_MASK        4'hf
`define DPI_RST_MODE        6'h00
`define DPI_RST_CFG         8'h00
`define DPI_RST_INDEX       8'h00
`define DPI_RST_TEMP        8'h00
`define DPI_RST_WORD        16'h0000

// ====================================================================
// Clocks from I/O write strobe to late memory read strobe
`define DPI_MEMORY_READ_STROBE_LATE_CYCLES 1

`endif

// file: design/dpi_pkg.sv
// Types shared by the DMA program port
package dpi_pkg;

   // ==================================================================
   // Channel operating style
   typedef enum logic [1:0] {
      DPI_STYLE_DEMAND  = 2'h0,
      DPI_STYLE_SINGLE  = 2'h1,
      DPI_STYLE_BLOCK   = 2'h2,
      DPI_STYLE_CASCADE = 2'h3
   } dpi_style_t;

   // Transfer type; code 3 is illegal
   typedef enum logic [1:0] {
      DPI_XFER_VERIFY  = 2'h0,
      DPI_XFER_WRITE   = 2'h1,
      DPI_XFER_READ    = 2'h2,
      DPI_XFER_ILLEGAL = 2'h3
   } dpi_xfer_t;

   // Per-channel mode as stored
   typedef struct packed {
      dpi_style_t style;
      logic       decrement;
      logic       auto_init;
      dpi_xfer_t  xfer;
   } dpi_mode_t;

   // Bus timing configuration as stored
   typedef struct packed {
      logic [1:0] io_ws;
      logic [1:0] dma16_ws;
      logic [1:0] dma8_ws;
      logic       early_read;
      logic       clock_select;
   } dpi_cfg_t;

endpackage

// file: testbench/dpi_host.sv
// Host CPU model issuing byte I/O reads and writes to the DMA port
`timescale 1ns/100ps

// ====================================================================
// Host bus model
module dpi_host
(
   input  wire logic       clk_in,
   input  wire logic [7:0] data_in,
   input  wire logic       oe_n_in,
   output logic      [9:0] addr_out,
   output logic            rd_n_out,
   output logic            wr_n_out,
   output logic      [7:0] data_out
);

   // Idle bus: both strobes high
   initial
   begin
      addr_out = 10'h000;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      data_out = 8'h00;
   end

   // Write: strobe low across one rising edge, then at least one high edge
   task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      data_out = d;
      wr_n_out = 1'b0;
      @(negedge clk_in);
      wr_n_out = 1'b1;
      // Released lines show the inverse so stale data never looks valid
      data_out = ~d;
      @(negedge clk_in);
   endtask

   // Read: hold strobe until the answer edge, take data only if driven
   task automatic io_rd(input logic [9:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      rd_n_out = 1'b0;
      repeat (2) @(negedge clk_in);
      d = oe_n_in ? 8'hxx : data_in;
      rd_n_out = 1'b1;
   endtask

endmodule

// file: testbench/dpi_top_chk.sv
// Pin-level assertions for the DMA program port
`timescale 1ns/100ps

// ====================================================================
// Checker
module dpi_chk
import dpi_pkg::*;
#(
   parameter int NUM_CH = 4
)
(
   input wire logic                  clk_in,
   input wire logic                  nrst_in,
   input wire logic [9:0]            io_addr_in,
   input wire logic                  io_read_strobe_n_in,
   input wire logic                  io_write_strobe_n_in,
   input wire logic [7:0]            buffered_data_lines_in,
   input wire logic                  buffered_data_lines_oe_n_out,
   input wire logic                  transfer_done_in,
   input wire logic                  io_write_strobe_n_out,
   input wire logic                  memory_read_strobe_n_out,
   input wire logic [NUM_CH-1:0]     channel_mask_out,
   input wire dpi_mode_t [NUM_CH-1:0] channel_mode_out,
   input wire logic                  illegal_mode_out,
   input wire logic [15:0]           current_address_out,
   input wire logic [15:0]           current_count_out
);
   logic [9:0] a;   // Short alias for the port address
   logic [7:0] wd;  // Short alias for the write data
   assign a = io_addr_in;
   assign wd = buffered_data_lines_in;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_mode_read;
      $fell(io_read_strobe_n_in) && a == 10'h00b |=>
         !buffered_data_lines_oe_n_out;
   endproperty
   a_mode_read: assert property (p_mode_read)
      else $error("mode read undriven");
   property p_wo_read;
      $fell(io_read_strobe_n_in) && a == 10'h00a |=>
         buffered_data_lines_oe_n_out;
   endproperty
   a_wo_read: assert property (p_wo_read)
      else $error("write-only port drove");
   property p_clear_all;
      $fell(io_write_strobe_n_in) && a == 10'h00e |=> channel_mask_out == '0;
   endproperty
   a_clear_all: assert property (p_clear_all)
      else $error("clear-mask left a mask");
   property p_mclear;
      $fell(io_write_strobe_n_in) && a == 10'h00d |=> &channel_mask_out;
   endproperty
   a_mclear: assert property (p_mclear)
      else $error("master clear did not mask all");
   property p_all_mask;
      $fell(io_write_strobe_n_in) && a == 10'h00f |=> channel_mask_out ==
         {$past(wd[0]), $past(wd[1]), $past(wd[2]), $past(wd[3])};
   endproperty
   a_all_mask: assert property (p_all_mask)
      else $error("all-mask bit order wrong");
   property p_one_mask;
      $fell(io_write_strobe_n_in) && a == 10'h00a |=>
         channel_mask_out[$past(wd[1:0])] == $past(wd[2]);
   endproperty
   a_one_mask: assert property (p_one_mask)
      else $error("single mask write wrong");
   property p_mode_wr;
      $fell(io_write_strobe_n_in) && a == 10'h00b |=>
         channel_mode_out[$past(wd[1:0])] == $past(wd[7:2]);
   endproperty
   a_mode_wr: assert property (p_mode_wr)
      else $error("mode write stored wrong");
   property p_illegal;
      $fell(io_write_strobe_n_in) && a == 10'h00b && wd[3:2] == 2'h3 |=>
         illegal_mode_out;
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("illegal type not flagged");
   property p_inc;
      transfer_done_in && io_write_strobe_n_in && current_count_out != 16'h0
         && !channel_mode_out[0].decrement
         |=> current_address_out == $past(current_address_out) + 16'h1;
   endproperty
   a_inc: assert property (p_inc)
      else $error("address did not increment");
   property p_memory_read_strobe;
      $fell(io_write_strobe_n_out) |-> ##[0:1] !memory_read_strobe_n_out;
   endproperty
   a_memory_read_strobe: assert property (p_memory_read_strobe)
      else $error("memory read strobe late");
endmodule

bind dpi_top dpi_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// file: testbench/tb_dma_program_interface.sv
// Self-checking bench for the DMA program port
`timescale 1ns/100ps

// ====================================================================
// Bench top
module tb_dma_program_interface;
   import dpi_pkg::*;
   logic            clk_in, nrst_in, copy_first, xfer_done, dstart, dend;
   logic [9:0]      addr;
   logic            rd_n, wr_n, oe_n, iow_n, memory_read_strobe_n, tc, illegal;
   logic [7:0]      wdata, dout, rdata;
   logic [3:0]      mask;
   dpi_mode_t [3:0] mode;
   logic [15:0]     cur_addr, cur_cnt;
   logic [2:0]      iows, d16ws, d8ws;
   int              fail_count = 0;
   int              compares = 0;

   dpi_host host (.clk_in(clk_in), .data_in(dout), .oe_n_in(oe_n),
      .addr_out(addr), .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(wdata));

   dpi_top #(.NUM_CH(4)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
      .io_addr_in(addr), .io_read_strobe_n_in(rd_n),
      .io_write_strobe_n_in(wr_n), .buffered_data_lines_in(wdata),
      .buffered_data_lines_out(dout), .buffered_data_lines_oe_n_out(oe_n),
      .mem_copy_first_in(copy_first), .transfer_done_in(xfer_done),
      .dma_io_write_start_in(dstart), .dma_cycle_end_in(dend),
      .io_write_strobe_n_out(iow_n), .memory_read_strobe_n_out(memory_read_strobe_n),
      .terminal_count_out(tc), .channel_mask_out(mask),
      .channel_mode_out(mode), .illegal_mode_out(illegal),
      .current_address_out(cur_addr), .current_count_out(cur_cnt),
      .io_wait_states_out(iows), .dma16_wait_states_out(d16ws),
      .dma8_wait_states_out(d8ws));

   // 250 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // ==================================================================
   // Shared helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle input pulse; returns once its edge has landed
   task automatic pulse(ref logic s);
      @(negedge clk_in);
      s = 1'b1;
      @(negedge clk_in);
      s = 1'b0;
   endtask
   // Mode byte per channel; channel 3 carries the illegal transfer type
   function automatic logic [7:0] mb(input logic [1:0] c);
      return {c, c[0], c[1], c, c};
   endfunction
   task automatic tally_and_finish;
      $display("Compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==================================================================
   // Scenarios
   task automatic t_reset;
      chk(mask, 16'hf);
      for (int c = 0; c < 4; c++)
         chk(mode[c], 16'h0);
      chk({iows, d16ws, d8ws}, 16'h049);
      chk({oe_n, iow_n, memory_read_strobe_n, tc}, 16'he);
      $display("t_reset done");
   endtask
   task automatic t_addr_count;
      host.io_wr(10'h00c, 8'hff);
      host.io_wr(10'h000, 8'h34);
      host.io_wr(10'h000, 8'h12);
      chk(cur_addr, 16'h1234);
      host.io_rd(10'h000, rdata);
      chk(rdata, 16'h34);
      host.io_rd(10'h000, rdata);
      chk(rdata, 16'h12);
      host.io_wr(10'h001, 8'h02);
      host.io_wr(10'h001, 8'h00);
      chk(cur_cnt, 16'h0002);
      host.io_rd(10'h00c, rdata);
      host.io_rd(10'h001, rdata);
      chk(rdata, 16'h00);
      host.io_rd(10'h00c, rdata);
      host.io_wr(10'h00c, 8'h5a);
      host.io_rd(10'h001, rdata);
      chk(rdata, 16'h02);
      host.io_wr(10'h00c, 8'h00);
      $display("t_addr_count done");
   endtask
   task automatic t_modes;
      for (int c = 0; c < 4; c++)
      begin
         host.io_wr(10'h00b, mb(c[1:0]));
         chk(mode[c], {8'h0, mb(c[1:0]) >> 2});
      end
      chk(illegal, 16'h1);
      host.io_rd(10'h00b, rdata);
      host.io_rd(10'h00e, rdata);
      for (int c = 0; c < 4; c++)
      begin
         host.io_rd(10'h00b, rdata);
         chk(rdata, mb(c[1:0]));
      end
      host.io_wr(10'h00b, 8'hf3);
      chk(illegal, 16'h0);
      $display("t_modes done");
   endtask
   task automatic t_xfer;
      pulse(xfer_done);
      chk(cur_addr, 16'h1235);
      chk(cur_cnt, 16'h0001);
      pulse(xfer_done);
      host.io_wr(10'h00b, 8'h30);
      pulse(xfer_done);
      chk(tc, 16'h1);
      chk(cur_cnt, 16'h0002);
      pulse(xfer_done);
      chk(tc, 16'h0);
      chk(cur_addr, 16'h1233);
      $display("t_xfer done");
   endtask
   task automatic t_masks;
      host.io_wr(10'h00e, 8'h00);
      chk(mask, 16'h0);
      host.io_wr(10'h00a, 8'h06);
      chk(mask, 16'h4);
      host.io_wr(10'h00a, 8'hfa);
      chk(mask, 16'h0);
      host.io_wr(10'h00f, 8'hf8);
      chk(mask, 16'h1);
      host.io_rd(10'h00a, rdata);
      chk(oe_n, 16'h1);
      host.io_wr(10'h000, 8'haa);
      host.io_wr(10'h00d, 8'h00);
      chk(mask, 16'hf);
      host.io_wr(10'h000, 8'h55);
      chk(cur_addr, 16'h1255);
      $display("t_masks done");
   endtask
   task automatic t_temp;
      host.data_out = 8'h5a;
      pulse(copy_first);
      host.io_rd(10'h00d, rdata);
      chk(rdata, 16'h5a);
      host.io_wr(10'h00d, 8'h00);
      host.io_rd(10'h00d, rdata);
      chk(rdata, 16'h00);
      $display("t_temp done");
   endtask
   task automatic t_cfg;
      for (int e = 0; e < 2; e++)
      begin
         host.io_wr(10'h022, 8'h01);
         host.io_wr(10'h023, {6'h39, e[0], 1'b1});
         chk({iows, d16ws, d8ws}, {3'h4, 3'h3, 3'h2});
         host.io_rd(10'h023, rdata);
         chk(rdata, {6'h39, e[0], 1'b1});
         pulse(dstart);
         chk({iow_n, memory_read_strobe_n}, {1'b0, ~e[0]});
         @(negedge clk_in);
         chk({iow_n, memory_read_strobe_n}, 16'h0);
         pulse(dend);
         chk({iow_n, memory_read_strobe_n}, 16'h3);
      end
      $display("t_cfg done");
   endtask

   // ==================================================================
   // Main sequence
   initial
   begin
      nrst_in = 1'b0;
      {copy_first, xfer_done, dstart, dend} = 4'h0;
      repeat (8) @(negedge clk_in);
      t_reset;
      nrst_in = 1'b1;
      t_addr_count;
      t_modes;
      t_xfer;
      t_masks;
      t_temp;
      t_cfg;
      tally_and_finish;
   end

   // Watchdog well past the roughly 150 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish;
   end
endmodule
